/* logic/efs_consts.svh */
// Register offsets, field positions, reset values and timing counts of the earth fault stage
`ifndef EFS_CONSTS_SVH
`define EFS_CONSTS_SVH
// ==========================================
// Register byte offsets
`define EFS_A_CTRL 8'h00
`define EFS_A_PICKUP 8'h04
`define EFS_A_UOPICK 8'h08
`define EFS_A_MTA 8'h0c
`define EFS_A_SECTOR 8'h10
`define EFS_A_TDEF 8'h14
`define EFS_A_KMUL 8'h18
`define EFS_A_INTRMT 8'h1c
`define EFS_A_USERC 8'h20
`define EFS_A_PASS 8'h34
`define EFS_A_FORCE 8'h38
`define EFS_A_STATUS 8'h3c
`define EFS_A_SCNT 8'h40
`define EFS_A_TCNT 8'h44
`define EFS_A_SUPV 8'h48
`define EFS_A_RECSEL 8'h50
`define EFS_A_RDATE 8'h54
`define EFS_A_RTIME 8'h58
`define EFS_A_RFLT 8'h5c
`define EFS_A_RMISC 8'h60
// ==========================================
// Control register field positions
`define EFS_F_MODE 0
`define EFS_F_INSEL 2
`define EFS_F_SUBSRC 4
`define EFS_F_SRCIDX 6
`define EFS_F_CURVE 9
`define EFS_F_TYPE 12
`define EFS_F_GRP 15
// ==========================================
// Reset values and constants
`define EFS_SECTOR_RST 8'h58
`define EFS_PASSWORD 32'h0000_5a5a
`define EFS_PCT_FULL 100
`define EFS_INV_SCALE 1000
// ==========================================
// Timing: clock period and delay tick, both in ns
`define EFS_CLK_NS 10
`define EFS_TICK_NS 1000000
`endif

/* logic/efs_pkg.sv */
// Types shared by the earth fault stage files
package efs_pkg;
  // Operating mode
  typedef enum logic [1:0] {EFS_RES_OR_CAP_MODE, EFS_SECTOR, EFS_UNDIR} efs_mode_e;
  // Supervised input
  typedef enum logic [1:0] {EFS_IN_MEAS, EFS_IN_CALC, EFS_IN_PEAK} efs_input_e;
  // Submode source
  typedef enum logic [1:0] {EFS_SRC_RES, EFS_SRC_CAP, EFS_SRC_DI, EFS_SRC_VI} efs_subsrc_e;
  // Submode in use, dash when not resistive/capacitive mode
  typedef enum logic [1:0] {EFS_SUB_DASH, EFS_SUB_RES, EFS_SUB_CAP} efs_sub_e;
  // Delay curve family
  typedef enum logic [2:0] {EFS_CRV_DT, EFS_CRV_IEC, EFS_CRV_IEEE, EFS_CRV_IEEE2, EFS_CRV_RI,
    EFS_CRV_PRG} efs_curve_e;
  // Delay type
  typedef enum logic [2:0] {EFS_T_DT, EFS_T_NI, EFS_T_VI, EFS_T_EI, EFS_T_LTI, EFS_T_PARAM} efs_type_e;
  // Fault state machine
  typedef enum logic [1:0] {EFS_IDLE, EFS_PICKED, EFS_INTERMIT} efs_state_e;
endpackage

/* logic/efs_sincos.sv */
// Sine and cosine of a signed angle in degrees, Q14 result
`timescale 1ns/1ns
module efs_sincos (
  // Angle in degrees, -180 to 180
  input wire logic signed [9:0] angle_deg,
  // Sine and cosine, 16384 means one
  output logic signed [15:0] sin_q,
  output logic signed [15:0] cos_q
);
  // Rational sine approximation, worst error about 0.2 percent
  function automatic logic signed [15:0] sin_of(input logic signed [10:0] a);
    logic signed [10:0] w;
    logic [7:0] x;
    logic [31:0] t;
    logic [31:0] q;
    w = a;
    if (w > 11'sd180) begin
      w = w - 11'sd360;
    end
    x = (w < 0) ? 8'(-w) : 8'(w);
    t = 32'(x) * (32'd180 - 32'(x));
    q = (t << 16) / (32'd40500 - t);
    sin_of = (w < 0) ? -$signed(q[15:0]) : $signed(q[15:0]);
  endfunction

  // Both outputs from the one approximation
  always_comb begin
    sin_q = sin_of(11'(angle_deg));
    cos_q = sin_of(11'(angle_deg) + 11'sd90);
  end
endmodule // efs_sincos

/* logic/efs_stage.sv */
// Directional earth fault stage with fault record and AHB-Lite register slave
// Function
// - Start when fundamental residual exceeds pick-up
// - Trip when start outlasts operation delay
// - Supervise fundamental component, third harmonic suppressed
// - Restart within intermittent time keeps delay count
// - Select measured or summed phase residual
// - Peak input only on first stage
// - Modes: resistive/capacitive, sector, undirectional
// - Angle offset rotates directional characteristic
// - Sector half width setting, default 88
// - Submode fixed or from digital/virtual input
// - Report submode: resistive, capacitive or dash
// - Voltage pick-up setting, report measured voltage
// - Definite or inverse delay, time or multiplier
// - Inverse types plus parameterised type using the first of five constants
// - Password settings, forced status, clearable counters
// - Keep eight latest faults with stamps, maxima
// - Record elapsed delay percent, 100 means trip
// - Record resistive or capacitive component in use
// - Record active setting group
// - Undirectional ignores angle and voltage
// - Sector trip area centred on offset
// - Capacitive submode uses capacitive half plane
`timescale 1ns/1ns
`include "efs_consts.svh"
module efs_stage #(
  parameter int DW = 16,
  parameter int REC_DEPTH = 8,
  parameter int STAGE_IDX = 1,
  parameter int NDI = 8,
  parameter int TICK_CYCLES = `EFS_TICK_NS / `EFS_CLK_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Measurement front end, fundamental phasors against -U0
  input wire logic signed [DW-1:0] io_re,
  input wire logic signed [DW-1:0] io_im,
  input wire logic signed [DW-1:0] il1_re,
  input wire logic signed [DW-1:0] il1_im,
  input wire logic signed [DW-1:0] il2_re,
  input wire logic signed [DW-1:0] il2_im,
  input wire logic signed [DW-1:0] il3_re,
  input wire logic signed [DW-1:0] il3_im,
  input wire logic [DW-1:0] peak_resid_input,
  input wire logic [7:0] resid_voltage_measured,
  // Submode control inputs and time stamp
  input wire logic [NDI-1:0] digital_in,
  input wire logic [NDI-1:0] virtual_in,
  input wire logic [31:0] date_stamp,
  input wire logic [31:0] time_ms,
  // Stage outputs
  output logic stage_start,
  output logic stage_trip
);
  // ==========================================
  // Types and state
  localparam int W = DW + 2;
  localparam int RW = $clog2(REC_DEPTH);
  // One fault record
  typedef struct packed {
    logic [31:0] date;
    logic [31:0] tod;
    logic [DW-1:0] flt;
    logic [DW-1:0] comp;
    logic [7:0] elapsed_delay_pct;
    logic [7:0] uo;
    logic [1:0] grp;
    efs_pkg::efs_sub_e sub;
  } efs_rec_s;
  // All state of the block
  typedef struct packed {
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic unlocked;
    logic force_on;
    logic force_start;
    logic force_trip;
    efs_pkg::efs_mode_e mode;
    efs_pkg::efs_input_e insel;
    efs_pkg::efs_subsrc_e subsrc;
    logic [2:0] src_idx;
    efs_pkg::efs_curve_e curve;
    efs_pkg::efs_type_e dtype;
    logic [1:0] setting_group_active;
    logic [DW-1:0] pickup;
    logic [7:0] uo_pick;
    logic signed [9:0] max_torque_angle;
    logic [7:0] sector;
    logic [31:0] tdef;
    logic [15:0] kmul;
    logic [31:0] intrmt;
    logic [4:0][15:0] userc;
    efs_pkg::efs_state_e st;
    logic [31:0] tick_cnt;
    logic [31:0] acc;
    logic [31:0] icnt;
    logic trip;
    logic o_start;
    logic o_trip;
    logic [31:0] scnt;
    logic [31:0] tcnt;
    efs_rec_s cur;
    logic [REC_DEPTH-1:0][$bits(efs_rec_s)-1:0] rec;
    logic [RW-1:0] rec_wp;
    logic [RW-1:0] rec_sel;
  } efs_state_s;
  efs_state_s s_ff;
  efs_state_s nxt_s;

  // ==========================================
  // Input selection and amplitude
  logic signed [W-1:0] sel_re;
  logic signed [W-1:0] sel_im;
  logic [W-1:0] abs_re;
  logic [W-1:0] abs_im;
  logic [W-1:0] amp_vec;
  logic [W-1:0] amp;
  logic peak_ok;
  always_comb begin
    unique case (s_ff.insel)
      efs_pkg::EFS_IN_CALC: begin
        sel_re = W'(il1_re) + W'(il2_re) + W'(il3_re);
        sel_im = W'(il1_im) + W'(il2_im) + W'(il3_im);
      end
      default: begin
        sel_re = W'(io_re);
        sel_im = W'(io_im);
      end
    endcase
  end
  // Magnitude estimate: larger part plus half the smaller
  assign abs_re = sel_re[W-1] ? W'(-sel_re) : W'(sel_re);
  assign abs_im = sel_im[W-1] ? W'(-sel_im) : W'(sel_im);
  assign amp_vec = (abs_re > abs_im) ? abs_re + (abs_im >> 1) : abs_im + (abs_re >> 1);
  assign peak_ok = (s_ff.insel == efs_pkg::EFS_IN_PEAK) && (STAGE_IDX == 1);
  assign amp = peak_ok ? W'(peak_resid_input) : amp_vec;

  // ==========================================
  // Directional characteristic
  logic signed [15:0] mta_sin;
  logic signed [15:0] mta_cos;
  logic signed [15:0] sec_sin;
  logic signed [15:0] sec_cos;
  logic signed [W+16:0] p_full;
  logic signed [W+16:0] q_full;
  logic signed [W:0] p;
  logic signed [W:0] q;
  logic signed [W+17:0] sec_x;
  logic signed [W:0] comp;
  logic in_sector;
  logic uo_ok;
  logic over_pick;
  logic start_cond;
  efs_pkg::efs_sub_e sub_now;
  // Offset angle sine and cosine
  efs_sincos u_mta (
    .angle_deg(s_ff.max_torque_angle),
    .sin_q(mta_sin),
    .cos_q(mta_cos)
  );
  // Half sector sine and cosine
  efs_sincos u_sec (
    .angle_deg($signed({2'b00, s_ff.sector})),
    .sin_q(sec_sin),
    .cos_q(sec_cos)
  );
  assign p_full = (W+17)'(sel_re) * (W+17)'(mta_cos) + (W+17)'(sel_im) * (W+17)'(mta_sin);
  assign q_full = (W+17)'(sel_im) * (W+17)'(mta_cos) - (W+17)'(sel_re) * (W+17)'(mta_sin);
  assign p = p_full[W+14:14];
  assign q = q_full[W+14:14];
  assign sec_x = (W+18)'(p) * (W+18)'(sec_sin) - (W+18)'(q[W] ? -q : q) * (W+18)'(sec_cos);
  assign in_sector = !sec_x[W+17];
  always_comb begin
    sub_now = efs_pkg::EFS_SUB_DASH;
    if (s_ff.mode == efs_pkg::EFS_RES_OR_CAP_MODE) begin
      unique case (s_ff.subsrc)
        efs_pkg::EFS_SRC_RES: sub_now = efs_pkg::EFS_SUB_RES;
        efs_pkg::EFS_SRC_CAP: sub_now = efs_pkg::EFS_SUB_CAP;
        efs_pkg::EFS_SRC_DI: sub_now = digital_in[s_ff.src_idx] ? efs_pkg::EFS_SUB_CAP : efs_pkg::EFS_SUB_RES;
        efs_pkg::EFS_SRC_VI: sub_now = virtual_in[s_ff.src_idx] ? efs_pkg::EFS_SUB_CAP : efs_pkg::EFS_SUB_RES;
      endcase
    end
  end
  assign comp = (sub_now == efs_pkg::EFS_SUB_CAP) ? q : p;
  assign uo_ok = resid_voltage_measured > s_ff.uo_pick;
  assign over_pick = amp > W'(s_ff.pickup);
  always_comb begin
    unique case (s_ff.mode)
      efs_pkg::EFS_RES_OR_CAP_MODE: start_cond = uo_ok && (comp > $signed((W+1)'(s_ff.pickup)));
      efs_pkg::EFS_SECTOR: start_cond = uo_ok && in_sector && over_pick;
      default: start_cond = over_pick;
    endcase
  end

  // ==========================================
  // Delay accumulation
  logic inv;
  logic [31:0] excess;
  logic [31:0] weight;
  logic [31:0] target;
  logic done;
  logic [7:0] elapsed_delay_pct_pct;
  logic [47:0] prod;
  // definite uses time, inverse uses multiplier
  assign inv = (s_ff.curve != efs_pkg::EFS_CRV_DT) && (s_ff.dtype != efs_pkg::EFS_T_DT);
  assign target = inv ? 32'(s_ff.kmul) * 32'(`EFS_INV_SCALE) : s_ff.tdef;
  assign excess = over_pick ? 32'(amp - W'(s_ff.pickup)) : 32'h0000_0000;
  always_comb begin
    prod = 48'(excess) * 48'(s_ff.userc[0]);
    unique case (s_ff.dtype)
      efs_pkg::EFS_T_NI: weight = excess;
      efs_pkg::EFS_T_VI: weight = excess << 1;
      efs_pkg::EFS_T_EI: weight = excess << 2;
      efs_pkg::EFS_T_LTI: weight = excess >> 2;
      efs_pkg::EFS_T_PARAM: weight = prod[39:8];
      default: weight = 32'h0000_0001;
    endcase
    if (!inv) begin
      weight = 32'h0000_0001;
    end
  end
  assign done = s_ff.acc >= target;
  assign elapsed_delay_pct_pct = (done || s_ff.trip) ? 8'(`EFS_PCT_FULL)
                  : 8'((40'(s_ff.acc) * 40'(`EFS_PCT_FULL)) / 40'(target));

  // ==========================================
  // Register read multiplexer
  logic [7:0] rd_addr;
  logic [31:0] rd_val;
  logic [RW-1:0] rec_idx;
  efs_rec_s rec_rd;
  assign rd_addr = haddr[7:0];
  assign rec_idx = s_ff.rec_wp - RW'(1) - s_ff.rec_sel;
  assign rec_rd = efs_rec_s'(s_ff.rec[rec_idx]);
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (rd_addr)
      `EFS_A_CTRL: rd_val = 32'({s_ff.setting_group_active, s_ff.dtype, s_ff.curve, s_ff.src_idx, s_ff.subsrc, s_ff.insel,
                                 s_ff.mode});
      `EFS_A_PICKUP: rd_val = 32'(s_ff.pickup);
      `EFS_A_UOPICK: rd_val = 32'(s_ff.uo_pick);
      `EFS_A_MTA: rd_val = 32'($unsigned(s_ff.max_torque_angle));
      `EFS_A_SECTOR: rd_val = 32'(s_ff.sector);
      `EFS_A_TDEF: rd_val = s_ff.tdef;
      `EFS_A_KMUL: rd_val = 32'(s_ff.kmul);
      `EFS_A_INTRMT: rd_val = s_ff.intrmt;
      `EFS_A_PASS: rd_val = 32'(s_ff.unlocked);
      `EFS_A_FORCE: rd_val = 32'({s_ff.force_trip, s_ff.force_start, s_ff.force_on});
      `EFS_A_STATUS: rd_val = 32'({resid_voltage_measured, 4'h0, sub_now, s_ff.o_trip, s_ff.o_start});
      `EFS_A_SCNT: rd_val = s_ff.scnt;
      `EFS_A_TCNT: rd_val = s_ff.tcnt;
      `EFS_A_SUPV: rd_val = {16'(comp), 16'(amp)};
      `EFS_A_RECSEL: rd_val = 32'(s_ff.rec_sel);
      `EFS_A_RDATE: rd_val = rec_rd.date;
      `EFS_A_RTIME: rd_val = rec_rd.tod;
      `EFS_A_RFLT: rd_val = 32'({rec_rd.comp, rec_rd.flt});
      `EFS_A_RMISC: rd_val = 32'({rec_rd.sub, rec_rd.grp, rec_rd.uo, rec_rd.elapsed_delay_pct});
      default: begin
        // Five user constants occupy consecutive words
        for (int i = 0; i < 5; i++) begin
          if (rd_addr == 8'(`EFS_A_USERC + 4 * i)) begin
            rd_val = 32'(s_ff.userc[i]);
          end
        end
      end
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.hready = 1'b1;
    nxt_s.hresp = 1'b0;
    nxt_s.wr_pend = 1'b0;
    // Data phase of a write
    if (s_ff.wr_pend) begin
      if (s_ff.unlocked) begin
        unique case (s_ff.wr_addr)
          `EFS_A_CTRL: begin
            nxt_s.mode = efs_pkg::efs_mode_e'(hwdata[`EFS_F_MODE +: 2]);
            nxt_s.insel = efs_pkg::efs_input_e'(hwdata[`EFS_F_INSEL +: 2]);
            nxt_s.subsrc = efs_pkg::efs_subsrc_e'(hwdata[`EFS_F_SUBSRC +: 2]);
            nxt_s.src_idx = hwdata[`EFS_F_SRCIDX +: 3];
            nxt_s.curve = efs_pkg::efs_curve_e'(hwdata[`EFS_F_CURVE +: 3]);
            nxt_s.dtype = efs_pkg::efs_type_e'(hwdata[`EFS_F_TYPE +: 3]);
            nxt_s.setting_group_active = hwdata[`EFS_F_GRP +: 2];
          end
          `EFS_A_PICKUP: nxt_s.pickup = hwdata[DW-1:0];
          `EFS_A_UOPICK: nxt_s.uo_pick = hwdata[7:0];
          `EFS_A_MTA: nxt_s.max_torque_angle = $signed(hwdata[9:0]);
          `EFS_A_SECTOR: nxt_s.sector = hwdata[7:0];
          `EFS_A_TDEF: nxt_s.tdef = hwdata;
          `EFS_A_KMUL: nxt_s.kmul = hwdata[15:0];
          `EFS_A_INTRMT: nxt_s.intrmt = hwdata;
          `EFS_A_FORCE: nxt_s.force_on = hwdata[0];
          default: begin
            for (int i = 0; i < 5; i++) begin
              if (s_ff.wr_addr == 8'(`EFS_A_USERC + 4 * i)) begin
                nxt_s.userc[i] = hwdata[15:0];
              end
            end
          end
        endcase
      end
      if (s_ff.wr_addr == `EFS_A_PASS) begin
        nxt_s.unlocked = (hwdata == `EFS_PASSWORD);
      end
      if (s_ff.wr_addr == `EFS_A_FORCE && s_ff.force_on) begin
        nxt_s.force_start = hwdata[1];
        nxt_s.force_trip = hwdata[2];
      end
      if (s_ff.wr_addr == `EFS_A_RECSEL) begin
        nxt_s.rec_sel = hwdata[RW-1:0];
      end
    end
    // Forcing ends with the force flag
    if (!nxt_s.force_on) begin
      nxt_s.force_start = 1'b0;
      nxt_s.force_trip = 1'b0;
    end
    // Address phase
    if (hready && hsel && htrans[1]) begin
      if (hwrite) begin
        nxt_s.wr_pend = 1'b1;
        nxt_s.wr_addr = haddr[7:0];
      end else begin
        nxt_s.hrdata = rd_val;
      end
    end
    // Delay tick divider
    nxt_s.tick_cnt = (s_ff.tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : s_ff.tick_cnt + 32'h0000_0001;
    // Fault sequence
    unique case (s_ff.st)
      efs_pkg::EFS_IDLE: begin
        if (start_cond) begin
          nxt_s.st = efs_pkg::EFS_PICKED;
          nxt_s.acc = 32'h0000_0000;
          nxt_s.scnt = s_ff.scnt + 32'h0000_0001;
          nxt_s.cur = '0;
          nxt_s.cur.date = date_stamp;
          nxt_s.cur.tod = time_ms;
        end
      end
      efs_pkg::EFS_PICKED: begin
        if (!start_cond) begin
          nxt_s.st = efs_pkg::EFS_INTERMIT;
          nxt_s.icnt = 32'h0000_0000;
          nxt_s.trip = 1'b0;
          // store in ring of latest faults
          nxt_s.rec[s_ff.rec_wp] = {s_ff.cur.date, s_ff.cur.tod, s_ff.cur.flt, s_ff.cur.comp, elapsed_delay_pct_pct,
                                    s_ff.cur.uo, s_ff.setting_group_active, s_ff.cur.sub};
          nxt_s.rec_wp = s_ff.rec_wp + RW'(1);
        end else begin
          if (amp > W'(s_ff.cur.flt)) begin
            nxt_s.cur.flt = (amp > W'({DW{1'b1}})) ? {DW{1'b1}} : DW'(amp);
          end
          if (comp > $signed((W+1)'(s_ff.cur.comp))) begin
            nxt_s.cur.comp = (comp > $signed((W+1)'({DW{1'b1}}))) ? {DW{1'b1}} : DW'(comp);
          end
          nxt_s.cur.sub = sub_now;
          if (resid_voltage_measured > s_ff.cur.uo) begin
            nxt_s.cur.uo = resid_voltage_measured;
          end
          if (s_ff.tick_cnt == 32'(TICK_CYCLES - 1) && !done) begin
            nxt_s.acc = s_ff.acc + weight;
          end
          if (done && !s_ff.trip) begin
            nxt_s.trip = 1'b1;
            nxt_s.tcnt = s_ff.tcnt + 32'h0000_0001;
          end
        end
      end
      efs_pkg::EFS_INTERMIT: begin
        if (start_cond) begin
          nxt_s.st = efs_pkg::EFS_PICKED;
          nxt_s.scnt = s_ff.scnt + 32'h0000_0001;
          nxt_s.cur = '0;
          nxt_s.cur.date = date_stamp;
          nxt_s.cur.tod = time_ms;
        end else if (s_ff.tick_cnt == 32'(TICK_CYCLES - 1)) begin
          if (s_ff.icnt >= s_ff.intrmt) begin
            nxt_s.st = efs_pkg::EFS_IDLE;
            nxt_s.acc = 32'h0000_0000;
          end else begin
            nxt_s.icnt = s_ff.icnt + 32'h0000_0001;
          end
        end
      end
      default: nxt_s.st = efs_pkg::EFS_IDLE;
    endcase
    nxt_s.cur.grp = s_ff.setting_group_active;
    nxt_s.o_start = (nxt_s.st == efs_pkg::EFS_PICKED) || nxt_s.force_start;
    nxt_s.o_trip = nxt_s.trip || nxt_s.force_trip;
    // Counters may be cleared to zero
    if (s_ff.wr_pend && s_ff.wr_addr == `EFS_A_SCNT) begin
      nxt_s.scnt = 32'h0000_0000;
    end
    if (s_ff.wr_pend && s_ff.wr_addr == `EFS_A_TCNT) begin
      nxt_s.tcnt = 32'h0000_0000;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.hready <= 1'b1;
      s_ff.mode <= efs_pkg::EFS_UNDIR;
      s_ff.sector <= `EFS_SECTOR_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = s_ff.hready;
  assign hrdata = s_ff.hrdata;
  assign hresp = s_ff.hresp;
  assign stage_start = s_ff.o_start;
  assign stage_trip = s_ff.o_trip;
endmodule // efs_stage

/* tb/efs_checker.sv */
// Port assertions of the earth fault stage
`timescale 1ns/1ns
module efs_checker #(
  parameter int DW = 16
) (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Phasors and stage outputs
  input wire logic signed [DW-1:0] io_re,
  input wire logic signed [DW-1:0] io_im,
  input wire logic signed [DW-1:0] il1_re,
  input wire logic signed [DW-1:0] il1_im,
  input wire logic signed [DW-1:0] il2_re,
  input wire logic signed [DW-1:0] il2_im,
  input wire logic signed [DW-1:0] il3_re,
  input wire logic signed [DW-1:0] il3_im,
  input wire logic [DW-1:0] peak_resid_input,
  input wire logic stage_start,
  input wire logic stage_trip
);
  // ==========================================
  // Helpers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic rd_take; // Read address phase taken
  logic zero_in; // Every selectable source is zero
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign zero_in = io_re == 0 && io_im == 0 && peak_resid_input == 0 &&
    il1_re + il2_re + il3_re == 0 && il1_im + il2_im + il3_im == 0;
  // ==========================================
  // Assertions
  ready_high_a: assert property (hreadyout) else $error("bus wait seen");
  resp_okay_a: assert property (!hresp) else $error("error response");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata)) else $error("read data moved");
  unmapped_zero_a: assert property (rd_take && haddr[7:0] > 8'h60 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  zero_no_start_a: assert property (zero_in |=> !stage_start) else $error("start on zero input");
  start_cause_a: assert property ($rose(stage_start) |-> $past(!zero_in)) else $error("start without cause");
  trip_needs_start_a: assert property (stage_trip |-> stage_start) else $error("trip without start");
  trip_after_start_a: assert property ($rose(stage_trip) |-> $past(stage_start))
    else $error("trip before start");
endmodule // efs_checker
bind efs_stage efs_checker #(.DW(DW)) u_chk (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .io_re, .io_im, .il1_re, .il1_im, .il2_re, .il2_im, .il3_re, .il3_im,
  .peak_resid_input, .stage_start, .stage_trip);

/* tb/efs_front_end.sv */
// Measurement front end model feeding the earth fault stage
`timescale 1ns/1ns
module efs_front_end (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Targets from the bench
  input wire logic signed [15:0] re_tgt,
  input wire logic signed [15:0] im_tgt,
  input wire logic [7:0] u0_tgt,
  input wire logic slow,
  input wire logic zero_io,
  // Phasors to the stage
  output logic signed [15:0] io_re,
  output logic signed [15:0] io_im,
  output logic signed [15:0] il1_re,
  output logic signed [15:0] il1_im,
  output logic signed [15:0] il2_re,
  output logic signed [15:0] il2_im,
  output logic signed [15:0] il3_re,
  output logic signed [15:0] il3_im,
  output logic [15:0] peak,
  output logic [7:0] u0
);
  logic [1:0] div_ff; // Slow update divider
  logic signed [11:0] mix_ff; // Moving imbalance, small so no phase sum wraps
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_ff <= 2'h0;
      mix_ff <= 12'sh0;
    end else begin
      div_ff <= div_ff + 2'h1;
      mix_ff <= mix_ff + 12'sh25;
    end
  end
  // phase sum equals residual unless zero_io zeroes the measured residual
  // Refreshes in reset too, so no unknowns reach the stage
  always_ff @(posedge ref_clk) begin
    // Slow mode refreshes every fourth cycle
    if (!slow || div_ff == 2'h0) begin
      io_re <= zero_io ? 16'sh0 : re_tgt;
      io_im <= zero_io ? 16'sh0 : im_tgt;
      il1_re <= re_tgt + 16'(mix_ff);
      il2_re <= -16'(mix_ff);
      il3_re <= 16'sh0;
      il1_im <= im_tgt;
      il2_im <= 16'(mix_ff);
      il3_im <= -16'(mix_ff);
      peak <= re_tgt < 0 ? -re_tgt : re_tgt;
      u0 <= u0_tgt;
    end
  end
endmodule // efs_front_end

/* tb/tb.sv */
// Self-checking bench of the earth fault stage
`timescale 1ns/1ns
`include "efs_consts.svh"
module tb;
  // ==========================================
  // Signals
  logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, slow = 0, zero_io = 0;
  logic hready, hreadyout, hresp, stage_start, stage_trip;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, date = 32'h0001_0203, tms = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic signed [15:0] re_tgt = 0, im_tgt = 0, io_re, io_im, il1_re, il1_im, il2_re, il2_im, il3_re, il3_im;
  logic [15:0] peak;
  logic [7:0] u0_tgt = 0, u0, din = 0, vin = 0;
  int err_count = 0, check_count = 0, a, b, n;
  integer seed = 32'ha7de8de0;
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tms <= tms + 32'h1;
  efs_stage #(.TICK_CYCLES(10)) u_dut (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .io_re, .io_im, .il1_re, .il1_im, .il2_re, .il2_im, .il3_re,
    .il3_im, .peak_resid_input(peak), .resid_voltage_measured(u0), .digital_in(din), .virtual_in(vin),
    .date_stamp(date), .time_ms(tms), .stage_start, .stage_trip);
  efs_front_end u_fe (.ref_clk, .reset, .re_tgt, .im_tgt, .u0_tgt, .slow, .zero_io, .io_re, .io_im,
    .il1_re, .il1_im, .il2_re, .il2_im, .il3_re, .il3_im, .peak, .u0);
  // ==========================================
  // Tasks
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // One bus phase, ended by hready under a bound
  task automatic phase_end();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    phase_end();
    htrans <= 2'h0;
    hwdata <= d;
    phase_end();
    q = hrdata;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic setv(input int r, input int i);
    re_tgt <= 16'(r);
    im_tgt <= 16'(i);
  endtask
  // Amplitude estimate of one phasor
  function automatic int amp(input int r, input int i);
    int x, y;
    x = r < 0 ? -r : r;
    y = i < 0 ? -i : i;
    return (x > y ? x : y) + (x > y ? y : x) / 2;
  endfunction
  // Five short faults with a given gap
  task automatic pulses(input int gap, input logic e);
    logic [31:0] t0;
    setv(0, 0);
    wt(40);
    bus(0, `EFS_A_TCNT, 0);
    t0 = q;
    repeat (5) begin
      setv(150, 0);
      wt(12);
      setv(0, 0);
      wt(gap);
    end
    bus(0, `EFS_A_TCNT, 0);
    chk("intermittent trip", q != t0, e);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    wt(10);
    reset <= 1'b0;
    bus(0, `EFS_A_SECTOR, 0);
    chk("sector reset", q, 32'h58);
    bus(0, `EFS_A_CTRL, 0);
    chk("mode reset", q[1:0], 2'h2);
    bus(1, `EFS_A_PICKUP, 32'h37);
    bus(0, `EFS_A_PICKUP, 0);
    chk("locked pickup", q, 0);
    bus(0, 8'h64, 0);
    chk("unmapped read", q, 0);
    bus(1, `EFS_A_PASS, `EFS_PASSWORD);
    bus(1, `EFS_A_PICKUP, 32'h64);
    bus(1, `EFS_A_TDEF, 32'h3);
    bus(1, `EFS_A_INTRMT, 32'h2);
    bus(1, `EFS_A_CTRL, 32'h10002);
    bus(0, `EFS_A_PICKUP, 0);
    chk("pickup", q, 32'h64);
    // Random phasors, then both sides of the pick-up level
    for (n = 0; n < 26; n++) begin
      a = n < 24 ? $random(seed) % 160 : n + 76;
      b = n < 24 ? $random(seed) % 160 : 0;
      slow <= n[0];
      setv(a, b);
      wt(10);
      chk("start", stage_start, amp(a, b) > 100);
    end
    slow <= 1'b0;
    setv(0, 0);
    wt(40);
    setv(150, 0);
    wt(18);
    chk("early trip", stage_trip, 0);
    n = 0;
    while (stage_trip !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    chk("trip", stage_trip, 1);
    setv(0, 0);
    wt(4);
    chk("start drop", stage_start, 0);
    chk("trip drop", stage_trip, 0);
    bus(0, `EFS_A_RMISC, 0);
    chk("elapsed_delay_pct", q[7:0], 8'h64);
    chk("group", q[17:16], 2'h2);
    bus(0, `EFS_A_RFLT, 0);
    chk("flt", q[15:0], 16'h96);
    bus(0, `EFS_A_RDATE, 0);
    chk("date", q, date);
    pulses(50, 1'b0);
    pulses(5, 1'b1);
    // Summed phases and peak input against the measured input
    zero_io <= 1'b1;
    setv(150, 0);
    bus(1, `EFS_A_CTRL, 32'h10006);
    wt(6);
    chk("calc start", stage_start, 1);
    bus(1, `EFS_A_CTRL, 32'h1000a);
    wt(6);
    chk("peak start", stage_start, 1);
    bus(1, `EFS_A_CTRL, 32'h10002);
    wt(6);
    chk("meas start", stage_start, 0);
    zero_io <= 1'b0;
    u0_tgt <= 8'h28;
    din <= 8'h01;
    vin <= 8'hfe;
    for (n = 0; n < 4; n++) begin
      bus(1, `EFS_A_CTRL, 32'(n * 16));
      wt(4);
      bus(0, `EFS_A_STATUS, 0);
      chk("submode", q[3:2], (n == 1 || n == 2) ? 2'h2 : 2'h1);
      chk("res_or_cap_mode start", q[0], n == 0 || n == 3);
    end
    chk("voltage", q[15:8], 8'h28);
    bus(1, `EFS_A_CTRL, 32'h1);
    wt(2);
    bus(0, `EFS_A_STATUS, 0);
    chk("dash", q[3:2], 2'h0);
    chk("sector in", q[0], 1);
    bus(1, `EFS_A_MTA, 32'hb4);
    wt(4);
    chk("sector out", stage_start, 0);
    stop_test();
  end
endmodule // tb
